/* rtl/timer_pkg.sv */
package timer_pkg;

  // ------------------------------------------------------------------
  // register map, byte addresses
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TOP  = 8'h04;
  localparam logic [7:0] ADDR_CMP  = 8'h08;
  localparam logic [7:0] ADDR_CNT  = 8'h0C;
  localparam logic [7:0] ADDR_CAPT = 8'h10;
  localparam logic [7:0] ADDR_STS  = 8'h14;
  localparam logic [7:0] ADDR_IEN  = 8'h18;
  localparam logic [7:0] ADDR_WEN  = 8'h1C;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int CTL_MODE_LSB  = 0;
  localparam int CTL_CLKSEL    = 2;
  localparam int CTL_PRESC_LSB = 3;
  localparam int CTL_EN        = 6;
  localparam int CTL_CAPEN     = 7;
  localparam int CTL_RSTPIN    = 8;
  localparam int ST_OVF        = 0;
  localparam int ST_CMP        = 1;
  localparam int ST_CAP        = 2;

  // ------------------------------------------------------------------
  // reset values and bus answers
  // ------------------------------------------------------------------
  localparam logic [15:0] TOP_RST     = 16'hFFFF;
  localparam logic [15:0] CMP_RST     = 16'h7FFF;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    MODE_WDT  = 4'h1,
    MODE_CTC  = 4'h2,
    MODE_FPWM = 4'h4,
    MODE_PFC  = 4'h8
  } mode_e;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axil_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_s;

endpackage

/* rtl/timer_counter_pwm.sv */
`timescale 1ns/10ps
module timer_counter_pwm
  import timer_pkg::*;
#(
  parameter int          CNT_W    = 16,
  parameter logic [1:0]  SA_MODE  = 2'h2,
  parameter logic [15:0] SA_TOP   = 16'hFFFF,
  parameter logic [15:0] SA_CMP   = 16'h8000,
  parameter logic [2:0]  SA_PRESC = 3'h0
) (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // register bus
  input  wire axil_req_s  axi_req,
  output axil_rsp_s       axi_rsp,
  // timer pins
  input  wire logic       timer_input_clock,
  input  wire logic       timer_reset_low,
  input  wire logic       capture_trigger_in,
  input  wire logic       standalone_en,
  // outputs
  output logic            timer_waveform_out,
  output logic            timer_interrupt_out,
  output logic            wake_request_out
);

  if (CNT_W < 2 || CNT_W > 16) begin : g_chk
    $error("CNT_W must lie between 2 and 16");
  end

  typedef logic [CNT_W-1:0] cnt_t;

  typedef struct packed {
    logic [2:0]  sync1;
    logic [2:0]  sync2;
    logic        clk_prev;
    logic        ic_prev;
    mode_e       mode;
    logic        clk_sel;
    logic [2:0]  presc;
    logic        en;
    logic        cap_en;
    cnt_t        top;
    cnt_t        cmp;
    cnt_t        top_act;
    cnt_t        cmp_act;
    cnt_t        cnt;
    cnt_t        cap;
    logic        down;
    logic [6:0]  ps;
    logic        out;
    logic [2:0]  sts;
    logic [2:0]  ien;
    logic [2:0]  wen;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_s;

  state_s q;
  state_s d;

  // ------------------------------------------------------------------
  // register readback
  // ------------------------------------------------------------------
  function automatic logic [1:0] mode_code(input mode_e m);
    case (m)
      MODE_WDT:  return 2'h0;
      MODE_CTC:  return 2'h1;
      MODE_FPWM: return 2'h2;
      default:   return 2'h3;
    endcase
  endfunction

  function automatic mode_e mode_dec(input logic [1:0] c);
    case (c)
      2'h0:    return MODE_WDT;
      2'h1:    return MODE_CTC;
      2'h2:    return MODE_FPWM;
      default: return MODE_PFC;
    endcase
  endfunction

  // returns {hit, data}
  function automatic logic [32:0] reg_read(input state_s s,
                                           input logic [7:0] a);
    logic [31:0] v;
    logic        hit;
    v   = '0;
    hit = 1'b1;
    case (a)
      ADDR_CTRL: begin
        v[CTL_MODE_LSB+:2]  = mode_code(s.mode);
        v[CTL_CLKSEL]       = s.clk_sel;
        v[CTL_PRESC_LSB+:3] = s.presc;
        v[CTL_EN]           = s.en;
        v[CTL_CAPEN]        = s.cap_en;
        v[CTL_RSTPIN]       = 1'b1;
      end
      ADDR_TOP:  v[CNT_W-1:0] = s.top;
      ADDR_CMP:  v[CNT_W-1:0] = s.cmp;
      ADDR_CNT:  v[CNT_W-1:0] = s.cnt;
      ADDR_CAPT: v[CNT_W-1:0] = s.cap;
      ADDR_STS:  v[2:0] = s.sts;
      ADDR_IEN:  v[2:0] = s.ien;
      ADDR_WEN:  v[2:0] = s.wen;
      default:   hit = 1'b0;
    endcase
    return {hit, v};
  endfunction

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  logic        pin_clk;
  logic        rst_pin_low;
  logic        ic;
  logic        src_edge;
  logic        tick;
  logic [6:0]  ps_lim;
  logic        ovf_ev;
  logic        cmp_ev;
  logic        cap_ev;
  logic        wr_go;
  logic [32:0] wr_cur;
  logic [31:0] wv;
  logic [32:0] rd_res;
  logic [2:0]  sts_clr;

  always_comb begin
    d = q;
    // pins pass two flops before use
    d.sync1     = {timer_input_clock, timer_reset_low, capture_trigger_in};
    d.sync2     = q.sync1;
    pin_clk     = q.sync2[2];
    rst_pin_low = !q.sync2[1];
    ic          = q.sync2[0];
    d.clk_prev  = pin_clk;
    d.ic_prev   = ic;

    src_edge = q.clk_sel ? (pin_clk & !q.clk_prev) : 1'b1;
    ps_lim   = 7'((8'h01 << q.presc) - 8'h01);
    tick     = q.en && src_edge && (q.ps == ps_lim);
    if (q.en && src_edge) begin
      d.ps = (q.ps == ps_lim) ? 7'h00 : q.ps + 7'h01;
    end

    ovf_ev = 1'b0;
    cmp_ev = 1'b0;
    if (tick) begin
      case (q.mode)
        MODE_WDT: begin
          if (q.cnt == q.top_act) begin
            d.cnt     = '0;
            d.top_act = q.top;
            d.out     = !q.out;
            ovf_ev    = 1'b1;
          end else begin
            d.cnt = q.cnt + cnt_t'(1);
          end
        end
        MODE_CTC: begin
          ovf_ev = &q.cnt;
          if (q.cnt == q.cmp_act) begin
            d.cnt     = '0;
            d.cmp_act = q.cmp;
            d.out     = !q.out;
            cmp_ev    = 1'b1;
          end else begin
            d.cnt = q.cnt + cnt_t'(1);
          end
        end
        MODE_FPWM: begin
          cmp_ev = (q.cnt == q.cmp_act);
          // shadows load only at the wrap
          if (q.cnt == q.top_act) begin
            d.cnt     = '0;
            d.top_act = q.top;
            d.cmp_act = q.cmp;
            ovf_ev    = 1'b1;
          end else begin
            d.cnt = q.cnt + cnt_t'(1);
          end
        end
        MODE_PFC: begin
          cmp_ev = (q.cnt == q.cmp_act);
          if (!q.down) begin
            if (q.cnt == q.top_act) begin
              d.down = (q.cnt != '0);
              d.cnt  = (q.cnt == '0) ? q.cnt : q.cnt - cnt_t'(1);
            end else begin
              d.cnt = q.cnt + cnt_t'(1);
            end
          end else if (q.cnt == '0) begin
            // both shadows load at the bottom, symmetric periods
            d.down    = 1'b0;
            d.top_act = q.top;
            d.cmp_act = q.cmp;
            d.cnt     = (q.top == '0) ? '0 : cnt_t'(1);
            ovf_ev    = 1'b1;
          end else begin
            d.cnt = q.cnt - cnt_t'(1);
          end
        end
        default: d.cnt = '0;
      endcase
      if (q.mode == MODE_FPWM || q.mode == MODE_PFC) begin
        d.out = (d.cnt < d.cmp_act);
      end
    end

    cap_ev = ic && !q.ic_prev && q.cap_en && !standalone_en &&
             (q.mode == MODE_WDT || q.mode == MODE_CTC);
    if (cap_ev) begin
      d.cap = q.cnt;
    end

    // write channel, taken in either order
    if (axi_req.awvalid && axi_rsp.awready) begin
      d.aw_got = 1'b1;
      d.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && axi_rsp.wready) begin
      d.w_got = 1'b1;
      d.wdata = axi_req.wdata;
      d.wstrb = axi_req.wstrb;
    end
    if (q.bvalid && axi_req.bready) begin
      d.bvalid = 1'b0;
    end
    wr_go   = q.aw_got && q.w_got;
    wr_cur  = reg_read(q, q.awaddr);
    sts_clr = '0;
    for (int i = 0; i < 4; i++) begin
      wv[i*8+:8] = q.wstrb[i] ? q.wdata[i*8+:8] : wr_cur[i*8+:8];
    end
    if (wr_go) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = wr_cur[32] ? RESP_OKAY : RESP_SLVERR;
      case (q.awaddr)
        ADDR_CTRL: begin
          d.mode    = mode_dec(wv[CTL_MODE_LSB+:2]);
          d.clk_sel = wv[CTL_CLKSEL];
          d.presc   = wv[CTL_PRESC_LSB+:3];
          d.en      = wv[CTL_EN];
          d.cap_en  = wv[CTL_CAPEN];
        end
        ADDR_TOP: d.top = wv[CNT_W-1:0];
        ADDR_CMP: d.cmp = wv[CNT_W-1:0];
        // write one to clear
        ADDR_STS: sts_clr = q.wstrb[0] ? q.wdata[2:0] : 3'h0;
        ADDR_IEN: d.ien = wv[2:0];
        ADDR_WEN: d.wen = wv[2:0];
        default: ;
      endcase
    end

    rd_res = reg_read(q, axi_req.araddr);
    if (axi_req.arvalid && axi_rsp.arready) begin
      d.rvalid = 1'b1;
      d.rdata  = rd_res[31:0];
      d.rresp  = rd_res[32] ? RESP_OKAY : RESP_SLVERR;
    end else if (q.rvalid && axi_req.rready) begin
      d.rvalid = 1'b0;
    end

    // sticky flags, a new event beats a clear
    d.sts = (q.sts & ~sts_clr) | {cap_ev, cmp_ev, ovf_ev};

    if (standalone_en) begin
      d.mode    = mode_dec(SA_MODE);
      d.top     = cnt_t'(SA_TOP);
      d.cmp     = cnt_t'(SA_CMP);
      d.presc   = SA_PRESC;
      d.clk_sel = 1'b1;
      d.en      = 1'b1;
      d.cap_en  = 1'b0;
    end

    // pin reset always enabled, clears the timer
    if (rst_pin_low) begin
      d.cnt  = '0;
      d.ps   = '0;
      d.down = 1'b0;
      d.out  = 1'b0;
      d.sts  = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q         <= '0;
      q.mode    <= MODE_WDT;
      q.top     <= cnt_t'(TOP_RST);
      q.cmp     <= cnt_t'(CMP_RST);
      q.top_act <= cnt_t'(TOP_RST);
      q.cmp_act <= cnt_t'(CMP_RST);
      q.sync1   <= 3'h2;
      q.sync2   <= 3'h2;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  // one process drives the whole response struct, never member by member
  always_comb begin
    axi_rsp.awready = !q.aw_got && !q.bvalid;
    axi_rsp.wready  = !q.w_got && !q.bvalid;
    axi_rsp.bvalid  = q.bvalid;
    axi_rsp.bresp   = q.bresp;
    axi_rsp.arready = !q.rvalid;
    axi_rsp.rvalid  = q.rvalid;
    axi_rsp.rdata   = q.rdata;
    axi_rsp.rresp   = q.rresp;
  end

  assign timer_waveform_out = q.out;
  assign timer_interrupt_out = standalone_en ? q.sts[ST_OVF]
                                             : |(q.sts & q.ien);
  assign wake_request_out = |(q.sts & q.wen);

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_mode_onehot: assert property ($onehot(q.mode))
    else $error("mode not one-hot");
  chk_pin_clear: assert property (rst_pin_low |=>
    q.cnt == '0 && !q.out && q.sts == '0)
    else $error("reset pin did not clear timer");
  chk_capture_stamp: assert property (cap_ev && !rst_pin_low |=>
    q.cap == $past(q.cnt) && q.sts[ST_CAP])
    else $error("capture lost");
  chk_ovf_flag: assert property (ovf_ev && !rst_pin_low |=>
    q.sts[ST_OVF])
    else $error("overflow flag not set");
  chk_shadow_load: assert property ($changed(q.top_act) &&
    q.mode == MODE_FPWM && $past(q.mode) == MODE_FPWM |->
    q.cnt == '0)
    else $error("period changed mid cycle");
  chk_presc_step: assert property (q.en && !q.clk_sel &&
    q.presc == 3'h1 && q.mode == MODE_WDT && !rst_pin_low &&
    !standalone_en && q.cnt < q.top_act - cnt_t'(2) ##1
    (q.mode == MODE_WDT && !rst_pin_low && !standalone_en &&
     q.en && !q.clk_sel && q.presc == 3'h1)[*2]
    |-> q.cnt == $past(q.cnt, 2) + cnt_t'(1))
    else $error("prescaler step wrong");
  chk_irq_gate: assert property (!standalone_en &&
    $rose(q.sts[ST_CMP]) && q.ien[ST_CMP] |-> timer_interrupt_out)
    else $error("irq not raised");
  chk_wake_gate: assert property (q.wen == '0 |->
    !wake_request_out)
    else $error("wake without enable");
  chk_write_resp: assert property (q.aw_got && q.w_got |=>
    axi_rsp.bvalid ##0 (axi_rsp.bvalid && !axi_rsp.awready))
    else $error("write response missing");
  chk_count_bound: assert property (q.mode == MODE_PFC &&
    $stable(q.top_act) && $past(q.cnt) <= q.top_act |->
    q.cnt <= q.top_act)
    else $error("counter beyond top");

  cov_capture: cover property (cap_ev);
  cov_pfc_wrap: cover property (q.mode == MODE_PFC && ovf_ev);
  cov_wr_rd: cover property (axi_rsp.bvalid ##[1:20] axi_rsp.rvalid);

endmodule // timer_counter_pwm

/* testbench/axil_host.sv */
`timescale 1ns/10ps
module axil_host
  import timer_pkg::*;
(
  // clock
  input  wire logic      aclk,
  // register bus
  output axil_req_s      axi_req,
  input  wire axil_rsp_s axi_rsp
);
  // ------------------------------------------------------------------
  // bus cycles
  // ------------------------------------------------------------------
  initial axi_req = '0;

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] resp, output logic ok);
    ok   = 1'b0;
    resp = 2'h3;
    @(posedge aclk);
    axi_req.awaddr  <= a;
    axi_req.wdata   <= d;
    axi_req.wstrb   <= 4'hF;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid  <= 1'b1;
    axi_req.bready  <= 1'b1;
    for (int n = 0; n < 200 && !ok; n++) begin
      @(posedge aclk);
      if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
      if (axi_rsp.bvalid) begin
        resp = axi_rsp.bresp;
        ok   = 1'b1;
        axi_req.bready <= 1'b0;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic ok);
    ok = 1'b0;
    @(posedge aclk);
    axi_req.araddr  <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready  <= 1'b1;
    for (int n = 0; n < 200 && !ok; n++) begin
      @(posedge aclk);
      if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
      if (axi_rsp.rvalid) begin
        ok = 1'b1;
        axi_req.rready <= 1'b0;
      end
    end
  endtask
endmodule // axil_host

/* testbench/timer_counter_pwm_tb.sv */
`timescale 1ns/10ps
module timer_counter_pwm_tb
  import timer_pkg::*;
;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        timer_input_clock = 1'b0;
  logic        timer_reset_low = 1'b1;
  logic        capture_trigger_in = 1'b0;
  logic        standalone_en = 1'b0;
  axil_req_s   axi_req;
  axil_rsp_s   axi_rsp;
  logic        timer_waveform_out;
  logic        timer_interrupt_out;
  logic        wake_request_out;
  int          errors = 0;
  int          cmp_count = 0;
  int          hi;
  logic [33:0] exp_q[$];
  logic [31:0] r;
  logic [7:0]  ra[9] = '{ADDR_CTRL, ADDR_TOP, ADDR_CMP, ADDR_CNT,
                         ADDR_CAPT, ADDR_STS, ADDR_IEN, ADDR_WEN, 8'h20};
  logic [31:0] rv[9] = '{32'h100, 32'hFFFF, 32'h7FFF, 32'h0,
                         32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

  timer_counter_pwm i_timer_counter_pwm (
    .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .timer_input_clock(timer_input_clock),
    .timer_reset_low(timer_reset_low),
    .capture_trigger_in(capture_trigger_in),
    .standalone_en(standalone_en),
    .timer_waveform_out(timer_waveform_out),
    .timer_interrupt_out(timer_interrupt_out),
    .wake_request_out(wake_request_out));

  axil_host i_axil_host (.aclk(aclk), .axi_req(axi_req), .axi_rsp(axi_rsp));

  initial forever #50 aclk = ~aclk;
  always @(posedge aclk) timer_input_clock <= ~timer_input_clock;

  // ------------------------------------------------------------------
  // checking
  // ------------------------------------------------------------------
  task automatic close_out();
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hang();
    errors++;
    $display("wrong value at %0t: no answer", $time);
    close_out();
  endtask

  // read results are matched against the oldest note
  always @(posedge aclk) begin
    if (aresetn && axi_rsp.rvalid && axi_req.rready) begin
      if (exp_q.size() == 0) hang();
      else chk({axi_rsp.rresp, axi_rsp.rdata}, exp_q.pop_front());
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic [1:0] resp;
    logic       ok;
    i_axil_host.wr(a, d, resp, ok);
    if (!ok) hang();
    chk({32'h0, resp}, {32'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic ok;
    exp_q.push_back({er, d});
    i_axil_host.rd(a, ok);
    if (!ok) hang();
  endtask

  task automatic wait_irq(input int lim);
    int n;
    for (n = 0; n < lim && timer_interrupt_out !== 1'b1; n++)
      @(posedge aclk);
    if (n == lim) hang();
  endtask

  task automatic count_hi(input int n, output int k);
    k = 0;
    repeat (n) begin
      @(posedge aclk);
      if (timer_waveform_out === 1'b1) k++;
    end
  endtask

  task automatic pulse_cap();
    @(posedge aclk);
    capture_trigger_in <= 1'b1;
    repeat (4) @(posedge aclk);
    capture_trigger_in <= 1'b0;
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  initial begin
    void'($urandom(32'h5AB2A9DA));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 9; i++)
      rd(ra[i], rv[i], (i == 8) ? RESP_SLVERR : RESP_OKAY);
    wr(8'h24, 32'h1, RESP_SLVERR);
    // pin reset enable cannot be cleared
    wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    rd(ADDR_CTRL, 32'h100, RESP_OKAY);
    r = $urandom;
    wr(ADDR_CMP, {16'h0, r[15:0]}, RESP_OKAY);
    rd(ADDR_CMP, {16'h0, r[15:0]}, RESP_OKAY);
    // fast pwm, overflow reaches irq and wake
    wr(ADDR_IEN, 32'h1, RESP_OKAY);
    wr(ADDR_WEN, 32'h1, RESP_OKAY);
    wr(ADDR_TOP, 32'h9, RESP_OKAY);
    wr(ADDR_CMP, 32'h3, RESP_OKAY);
    wr(ADDR_CTRL, 32'h42, RESP_OKAY);
    wait_irq(70000);
    chk({33'h0, wake_request_out}, 34'h1);
    wr(ADDR_IEN, 32'h0, RESP_OKAY);
    @(posedge aclk);
    chk({33'h0, timer_interrupt_out}, 34'h0);
    // period of ten, three cycles high
    count_hi(100, hi);
    chk(34'(hi), 34'd30);
    // compare cause reaches the irq once enabled
    wr(ADDR_IEN, 32'h2, RESP_OKAY);
    wr(ADDR_STS, 32'h2, RESP_OKAY);
    wait_irq(20);
    // capture ignored while disabled, taken when enabled
    wr(ADDR_CTRL, 32'h41, RESP_OKAY);
    wr(ADDR_IEN, 32'h4, RESP_OKAY);
    wr(ADDR_STS, 32'h7, RESP_OKAY);
    pulse_cap();
    repeat (10) @(posedge aclk);
    chk({33'h0, timer_interrupt_out}, 34'h0);
    wr(ADDR_CTRL, 32'hC1, RESP_OKAY);
    pulse_cap();
    wait_irq(10);
    // reset pin clears counter, flags and output
    timer_reset_low <= 1'b0;
    repeat (5) @(posedge aclk);
    chk({32'h0, timer_waveform_out, timer_interrupt_out}, 34'h0);
    chk({33'h0, wake_request_out}, 34'h0);
    rd(ADDR_CNT, 32'h0, RESP_OKAY);
    rd(ADDR_STS, 32'h0, RESP_OKAY);
    timer_reset_low <= 1'b1;
    // dual-slope period of eighteen, five cycles high
    wr(ADDR_CTRL, 32'h43, RESP_OKAY);
    repeat (20) @(posedge aclk);
    count_hi(180, hi);
    chk(34'(hi), 34'd50);
    // watchdog at half rate, output toggles every 20 cycles
    wr(ADDR_CTRL, 32'h48, RESP_OKAY);
    repeat (40) @(posedge aclk);
    count_hi(200, hi);
    chk(34'(hi), 34'd100);
    standalone_en <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(ADDR_CTRL, 32'h146, RESP_OKAY);
    repeat (3) @(posedge aclk);
    close_out();
  end
endmodule // timer_counter_pwm_tb
